//--- logic/frame_fetch_addr.sv
// frame start, pan and split-screen fetch address sequencer
// assumes frame_start and line_done are one-cycle pulses on clk
//
// What this block does
// - In landscape the top start value is a word offset giving the top-left pixel of a frame.
// - In landscape one unit of start value moves the image by one word of pixels.
// - In rotated mode the start value is a byte offset, halving the pan step.
// - The top start value is 15 bits: low register bits 7..0, high register 14..8, bit 7 reserved.
// - The top image always begins the frame and descends line by line from its start.
// - After the top vertical size in lines, lines are fetched from the bottom start value.
// - Line pitch in memory is displayed width plus the address offset.
// - The split may fall on any line, set only by the top vertical size.
// - The top vertical size is 10 bits over two registers; at or above panel lines there is no split.
// - Rotated mode has no split and ignores the bottom start value.
// - The address offset is 8 bits; zero means pitch equals the displayed width.
`timescale 1ns/1ps
module frame_fetch_addr
    import fsplit_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    // display timing
    input  wire logic              frame_start,
    input  wire logic              line_done,
    // fetch side
    output logic      [ADDR_W-1:0] fetch_addr,
    output logic                   fetch_bottom,
    output logic                   fetch_active
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // scaling and readback are packed by hand for these widths
    if (ADDR_W != START_W + 1) begin : g_addr_w_check
        $error("fetch address must be one bit wider than a start value");
    end
    if (ADDR_W != 16) begin : g_addr_bytes_check
        $error("fetch address readback covers exactly two bytes");
    end
    if (SIZE_W != 10) begin : g_size_w_check
        $error("line counter must match the two split size registers");
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    logic [7:0]  top_start_low;
    logic [6:0]  top_start_high;
    logic [7:0]  bot_start_low;
    logic [6:0]  bot_start_high;
    logic [7:0]  line_offset;
    logic [7:0]  top_size_low;
    logic [1:0]  top_size_high;
    logic        rotate;
    logic [7:0]  shown_width;
    logic [7:0]  panel_lines_low;
    logic [1:0]  panel_lines_high;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            top_start_low    <= REG_RESET;
            top_start_high   <= REG_RESET[6:0];
            bot_start_low    <= REG_RESET;
            bot_start_high   <= REG_RESET[6:0];
            line_offset      <= REG_RESET;
            top_size_low     <= REG_RESET;
            top_size_high    <= REG_RESET[1:0];
            rotate           <= 1'b0;
            shown_width      <= REG_RESET;
            panel_lines_low  <= REG_RESET;
            panel_lines_high <= REG_RESET[1:0];
        end else if (reg_wr) begin
            if (reg_addr == ADDR_TOP_START_LOW) begin
                top_start_low <= reg_wdata;
            end else if (reg_addr == ADDR_TOP_START_HIGH) begin
                top_start_high <= reg_wdata[6:0];
            end else if (reg_addr == ADDR_BOT_START_LOW) begin
                bot_start_low <= reg_wdata;
            end else if (reg_addr == ADDR_BOT_START_HIGH) begin
                bot_start_high <= reg_wdata[6:0];
            end else if (reg_addr == ADDR_LINE_OFFSET) begin
                line_offset <= reg_wdata;
            end else if (reg_addr == ADDR_TOP_SIZE_LOW) begin
                top_size_low <= reg_wdata;
            end else if (reg_addr == ADDR_TOP_SIZE_HIGH) begin
                top_size_high <= reg_wdata[1:0];
            end else if (reg_addr == ADDR_MODE) begin
                rotate <= reg_wdata[MODE_ROT_BIT];
            end else if (reg_addr == ADDR_SHOWN_WIDTH) begin
                shown_width <= reg_wdata;
            end else if (reg_addr == ADDR_PANEL_LINES_LO) begin
                panel_lines_low <= reg_wdata;
            end else if (reg_addr == ADDR_PANEL_LINES_HI) begin
                panel_lines_high <= reg_wdata[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // frame shadow copies
    // ------------------------------------------------------------
    // sampled once per frame so a half-written 15-bit value never tears a frame
    logic [START_W-1:0] sh_bot_start;
    logic [SIZE_W-1:0]  sh_top_size;
    logic [SIZE_W-1:0]  sh_panel_lines;
    logic [7:0]         sh_offset;
    logic [7:0]         sh_width;
    logic               sh_rotate;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sh_bot_start   <= '0;
            sh_top_size    <= '0;
            sh_panel_lines <= '0;
            sh_offset      <= '0;
            sh_width       <= '0;
            sh_rotate      <= 1'b0;
        end else if (frame_start) begin
            sh_bot_start   <= {bot_start_high, bot_start_low};
            sh_top_size    <= {top_size_high, top_size_low};
            sh_panel_lines <= {panel_lines_high, panel_lines_low};
            sh_offset      <= line_offset;
            sh_width       <= shown_width;
            sh_rotate      <= rotate;
        end
    end

    // ------------------------------------------------------------
    // address scaling
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] next_top_byte;
    logic [ADDR_W-1:0] bot_byte;
    logic [ADDR_W-1:0] pitch_units;
    logic [ADDR_W-1:0] pitch_bytes;
    logic [START_W-1:0] live_top_start;

    assign live_top_start = {top_start_high, top_start_low};

    always_comb begin
        // words count double in bytes; rotated values already are bytes
        if (rotate) begin
            next_top_byte = ADDR_W'(live_top_start);
        end else begin
            next_top_byte = {live_top_start, 1'b0};
        end
        if (sh_rotate) begin
            bot_byte = ADDR_W'(sh_bot_start);
        end else begin
            bot_byte = {sh_bot_start, 1'b0};
        end
        pitch_units = ADDR_W'(sh_width) + ADDR_W'(sh_offset);
        if (sh_rotate) begin
            pitch_bytes = pitch_units;
        end else begin
            pitch_bytes = {pitch_units[ADDR_W-2:0], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // frame sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_ACTIVE = 2'b10
    } seq_state_t;

    seq_state_t         state;
    logic [SIZE_W-1:0]  line_count;
    logic [SIZE_W-1:0]  next_line_count;
    logic               split_allowed;
    logic               take_bottom;

    assign next_line_count = line_count + 1'b1;
    // no split while rotated, nor when the top region covers the panel
    assign split_allowed = !sh_rotate && (sh_top_size < sh_panel_lines);
    assign take_bottom = (state == ST_ACTIVE) && line_done && split_allowed
                         && !fetch_bottom && (next_line_count == sh_top_size);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (frame_start) begin
                        state <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    state <= ST_ACTIVE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            line_count <= '0;
        end else if (frame_start) begin
            line_count <= '0;
        end else if (state == ST_ACTIVE && line_done) begin
            line_count <= next_line_count;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fetch_bottom <= 1'b0;
        end else if (frame_start) begin
            fetch_bottom <= 1'b0;
        end else if (take_bottom) begin
            fetch_bottom <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fetch_active <= 1'b0;
        end else if (frame_start) begin
            fetch_active <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // line address generator
    // ------------------------------------------------------------
    fetch_step_if #(.ADDR_W(ADDR_W)) fs ();

    always_comb begin
        fs.load       = frame_start || take_bottom;
        fs.load_value = frame_start ? next_top_byte : bot_byte;
        fs.step       = (state == ST_ACTIVE) && line_done && !take_bottom;
        fs.pitch      = pitch_bytes;
    end

    line_addr_gen u_gen (
        .clk    (clk),
        .resetn (resetn),
        .fs     (fs)
    );

    assign fetch_addr = fs.addr;

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= READ_UNMAPPED;
        end else if (!reg_rd) begin
            reg_rdata <= READ_UNMAPPED;
        end else if (reg_addr == ADDR_TOP_START_LOW) begin
            reg_rdata <= top_start_low;
        end else if (reg_addr == ADDR_TOP_START_HIGH) begin
            reg_rdata <= {1'b0, top_start_high};
        end else if (reg_addr == ADDR_BOT_START_LOW) begin
            reg_rdata <= bot_start_low;
        end else if (reg_addr == ADDR_BOT_START_HIGH) begin
            reg_rdata <= {1'b0, bot_start_high};
        end else if (reg_addr == ADDR_LINE_OFFSET) begin
            reg_rdata <= line_offset;
        end else if (reg_addr == ADDR_TOP_SIZE_LOW) begin
            reg_rdata <= top_size_low;
        end else if (reg_addr == ADDR_TOP_SIZE_HIGH) begin
            reg_rdata <= {6'h00, top_size_high};
        end else if (reg_addr == ADDR_MODE) begin
            reg_rdata <= {7'h00, rotate};
        end else if (reg_addr == ADDR_SHOWN_WIDTH) begin
            reg_rdata <= shown_width;
        end else if (reg_addr == ADDR_PANEL_LINES_LO) begin
            reg_rdata <= panel_lines_low;
        end else if (reg_addr == ADDR_PANEL_LINES_HI) begin
            reg_rdata <= {6'h00, panel_lines_high};
        end else if (reg_addr == ADDR_LINE_COUNT_LO) begin
            reg_rdata <= line_count[7:0];
        end else if (reg_addr == ADDR_LINE_COUNT_HI) begin
            reg_rdata <= {5'h00, fetch_bottom, line_count[9:8]};
        end else if (reg_addr == ADDR_FETCH_LO) begin
            reg_rdata <= fs.addr[7:0];
        end else if (reg_addr == ADDR_FETCH_HI) begin
            reg_rdata <= fs.addr[15:8];
        end else begin
            reg_rdata <= READ_UNMAPPED;
        end
    end

endmodule : frame_fetch_addr

//--- logic/fsplit_pkg.sv
// constants for the frame start, pan and split-screen fetch address block
// assumes a byte-wide register port and an 8-bit register index space
package fsplit_pkg;

    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_TOP_START_LOW  = 8'h0C;
    localparam logic [7:0] ADDR_TOP_START_HIGH = 8'h0D;
    localparam logic [7:0] ADDR_BOT_START_LOW  = 8'h0F;
    localparam logic [7:0] ADDR_BOT_START_HIGH = 8'h10;
    localparam logic [7:0] ADDR_LINE_OFFSET    = 8'h12;
    localparam logic [7:0] ADDR_TOP_SIZE_LOW   = 8'h13;
    localparam logic [7:0] ADDR_TOP_SIZE_HIGH  = 8'h14;
    localparam logic [7:0] ADDR_MODE           = 8'h20;
    localparam logic [7:0] ADDR_SHOWN_WIDTH    = 8'h21;
    localparam logic [7:0] ADDR_PANEL_LINES_LO = 8'h22;
    localparam logic [7:0] ADDR_PANEL_LINES_HI = 8'h23;
    localparam logic [7:0] ADDR_LINE_COUNT_LO  = 8'h24;
    localparam logic [7:0] ADDR_LINE_COUNT_HI  = 8'h25;
    localparam logic [7:0] ADDR_FETCH_LO       = 8'h26;
    localparam logic [7:0] ADDR_FETCH_HI       = 8'h27;

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int          START_W       = 15;
    localparam int          SIZE_W        = 10;
    localparam int          ADDR_W        = 16;
    localparam int          MODE_ROT_BIT  = 0;
    localparam logic [7:0]  REG_RESET     = 8'h00;
    localparam logic [7:0]  READ_UNMAPPED = 8'h00;

endpackage : fsplit_pkg

//--- logic/fetch_step_if.sv
// carrier between the frame sequencer and the line address generator
// assumes both ends share one clock
`timescale 1ns/1ps
interface fetch_step_if #(parameter int ADDR_W = 16);
    logic              load;
    logic [ADDR_W-1:0] load_value;
    logic              step;
    logic [ADDR_W-1:0] pitch;
    logic [ADDR_W-1:0] addr;

    modport ctrl (output load, output load_value, output step, output pitch, input addr);
    modport gen  (input load, input load_value, input step, input pitch, output addr);
endinterface : fetch_step_if

//--- logic/line_addr_gen.sv
// line start address accumulator
// assumes load and step never rise together; load wins if they do
`timescale 1ns/1ps
module line_addr_gen
    import fsplit_pkg::*;
(
    // clock and reset
    input  wire logic   clk,
    input  wire logic   resetn,
    // sequencer side
    fetch_step_if.gen   fs
);

    // ------------------------------------------------------------
    // accumulator
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fs.addr <= '0;
        end else if (fs.load) begin
            fs.addr <= fs.load_value;
        end else if (fs.step) begin
            // wraps modulo 2^ADDR_W; keeping inside the buffer is software's job
            fs.addr <= fs.addr + fs.pitch;
        end
    end

endmodule : line_addr_gen

//--- testbench/frame_fetch_addr_sva.sv
// checker for the frame fetch address block
// assumes it is bound to frame_fetch_addr and sees only its ports
`timescale 1ns/1ps
module frame_fetch_addr_sva
    import fsplit_pkg::*;
(
    // clock and reset
    input wire logic              clk,
    input wire logic              resetn,
    // register port
    input wire logic [7:0]        reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [7:0]        reg_rdata,
    // timing and fetch side
    input wire logic              frame_start,
    input wire logic              line_done,
    input wire logic [ADDR_W-1:0] fetch_addr,
    input wire logic              fetch_bottom,
    input wire logic              fetch_active
);
    // ------------------------------------------------
    // register shadows
    // ------------------------------------------------
    logic [7:0]        start_lo, width_q, offset_q;
    logic [6:0]        start_hi;
    logic              rot_q, rot_f;
    logic [ADDR_W-1:0] start_q, sum_q, pitch_f;
    assign start_q = {1'b0, start_hi, start_lo};
    assign sum_q   = {8'h00, width_q} + {8'h00, offset_q};
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {start_lo, start_hi, width_q, offset_q, rot_q} <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_TOP_START_LOW:  start_lo <= reg_wdata;
                ADDR_TOP_START_HIGH: start_hi <= reg_wdata[6:0];
                ADDR_SHOWN_WIDTH:    width_q  <= reg_wdata;
                ADDR_LINE_OFFSET:    offset_q <= reg_wdata;
                ADDR_MODE:           rot_q    <= reg_wdata[MODE_ROT_BIT];
                default: ;
            endcase
        end
    end
    // pitch follows the frame, so mid-frame writes cannot fool the step check
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rot_f   <= 1'b0;
            pitch_f <= '0;
        end else if (frame_start) begin
            rot_f   <= rot_q;
            pitch_f <= rot_q ? sum_q : sum_q << 1;
        end
    end
    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_top_line;
        line_done && !frame_start && fetch_active && !fetch_bottom;
    endsequence
    sequence s_bottom_rise;
        !fetch_bottom ##1 fetch_bottom;
    endsequence
    AST_TOP_LOW_READ: assert property (
        reg_rd && reg_addr == ADDR_TOP_START_LOW |=> reg_rdata == $past(start_lo))
        else $error("top start low reads wrong");
    AST_TOP_HIGH_READ: assert property (
        reg_rd && reg_addr == ADDR_TOP_START_HIGH |=> reg_rdata == {1'b0, $past(start_hi)})
        else $error("top start high reads wrong");
    AST_START_LAND: assert property (
        frame_start && !rot_q |=> fetch_addr == $past(start_q) << 1)
        else $error("landscape frame address wrong");
    AST_START_ROT: assert property (
        frame_start && rot_q |=> fetch_addr == $past(start_q))
        else $error("rotated frame address wrong");
    AST_TOP_FIRST: assert property (
        frame_start |=> !fetch_bottom && fetch_active)
        else $error("frame does not open on the top image");
    AST_LINE_STEP: assert property (
        s_top_line |=> fetch_bottom || fetch_addr == $past(fetch_addr) + pitch_f)
        else $error("line step wrong in top image");
    AST_BOTTOM_STEP: assert property (
        line_done && !frame_start && fetch_bottom
        |=> fetch_bottom && fetch_addr == $past(fetch_addr) + pitch_f)
        else $error("line step wrong in bottom image");
    AST_BOTTOM_RISE: assert property (
        s_bottom_rise |-> $past(line_done) && !$past(frame_start))
        else $error("bottom image entered without a line end");
    AST_ROT_NO_SPLIT: assert property (
        rot_f |-> !fetch_bottom)
        else $error("split shown in rotated mode");
    AST_HOLD: assert property (
        !frame_start && !line_done |=> $stable(fetch_addr) && $stable(fetch_bottom))
        else $error("fetch address moved without a timing pulse");
endmodule : frame_fetch_addr_sva

bind frame_fetch_addr frame_fetch_addr_sva frame_fetch_addr_sva_inst (.clk(clk),
    .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_start(frame_start),
    .line_done(line_done), .fetch_addr(fetch_addr), .fetch_bottom(fetch_bottom),
    .fetch_active(fetch_active));

//--- testbench/frame_fetch_addr_tb.sv
// testbench for the frame fetch address block
// assumes the package, interface and design files are compiled first
`timescale 1ns/1ps
module frame_fetch_addr_tb import fsplit_pkg::*;;
    // ------------------------------------------------
    // signals and design
    // ------------------------------------------------
    logic              clk = 1'b0;
    logic              resetn = 1'b0;
    logic [7:0]        reg_addr = 8'h00;
    logic [7:0]        reg_wdata = 8'h00;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic              frame_start = 1'b0;
    logic              line_done = 1'b0;
    logic [7:0]        reg_rdata;
    logic [ADDR_W-1:0] fetch_addr;
    logic              fetch_bottom;
    logic              fetch_active;
    int                miscompares = 0;
    int                comparisons = 0;
    always #2.5 clk = ~clk;
    frame_fetch_addr frame_fetch_addr_inst (.clk, .resetn, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .frame_start, .line_done, .fetch_addr,
        .fetch_bottom, .fetch_active);
    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    task automatic final_report();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
    endtask : rd
    // one frame or line pulse, outputs settled on return
    task automatic pulse(input logic fr);
        @(posedge clk);
        frame_start <= fr;
        line_done   <= !fr;
        @(posedge clk);
        frame_start <= 1'b0;
        line_done   <= 1'b0;
        #1;
    endtask : pulse
    task automatic at(input logic [15:0] addr, input logic bot);
        chk("fetch_addr", fetch_addr, addr);
        chk("fetch_bottom", {15'h0000, fetch_bottom}, {15'h0000, bot});
    endtask : at
    task automatic cfg(input logic rot, input logic [7:0] wid, input logic [7:0] off,
                       input logic [15:0] top, input logic [15:0] bot,
                       input logic [9:0] size, input logic [9:0] lines);
        wr(ADDR_MODE, {7'h00, rot});
        wr(ADDR_SHOWN_WIDTH, wid);
        wr(ADDR_LINE_OFFSET, off);
        wr(ADDR_TOP_START_LOW, top[7:0]);
        wr(ADDR_TOP_START_HIGH, top[15:8]);
        wr(ADDR_BOT_START_LOW, bot[7:0]);
        wr(ADDR_BOT_START_HIGH, bot[15:8]);
        wr(ADDR_TOP_SIZE_LOW, size[7:0]);
        wr(ADDR_TOP_SIZE_HIGH, {6'h00, size[9:8]});
        wr(ADDR_PANEL_LINES_LO, lines[7:0]);
        wr(ADDR_PANEL_LINES_HI, {6'h00, lines[9:8]});
    endtask : cfg
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_regs();
        pulse(1'b0);
        at(16'h0000, 1'b0);
        chk("fetch_active", {15'h0000, fetch_active}, 16'h0000);
        rd(ADDR_TOP_START_HIGH, REG_RESET);
        wr(ADDR_TOP_START_LOW, 8'hA5);
        wr(ADDR_TOP_START_HIGH, 8'hFF);
        rd(ADDR_TOP_START_LOW, 8'hA5);
        rd(ADDR_TOP_START_HIGH, 8'h7F);
        wr(8'h0E, 8'h5A);
        rd(8'h0E, READ_UNMAPPED);
        pulse(1'b1);
        at(16'hFF4A, 1'b0);
        chk("fetch_active", {15'h0000, fetch_active}, 16'h0001);
    endtask : t_regs
    task automatic t_land();
        cfg(1'b0, 8'h14, 8'h28, 16'h0C80, 16'h0000, 10'h3FF, 10'h0F0);
        pulse(1'b1);
        at(16'h1900, 1'b0);
        for (int i = 1; i <= 3; i++) begin
            pulse(1'b0);
            at(16'h1900 + 16'(i) * 16'h0078, 1'b0);
        end
        // mid-frame writes wait for the next frame
        wr(ADDR_TOP_START_LOW, 8'h81);
        wr(ADDR_LINE_OFFSET, 8'h00);
        pulse(1'b0);
        at(16'h1AE0, 1'b0);
        pulse(1'b1);
        at(16'h1902, 1'b0);
        pulse(1'b0);
        at(16'h192A, 1'b0);
        wr(ADDR_TOP_START_LOW, 8'h7F);
        pulse(1'b1);
        at(16'h18FE, 1'b0);
        wr(ADDR_LINE_OFFSET, 8'h28);
        wr(ADDR_TOP_START_LOW, 8'hBC);
        pulse(1'b1);
        at(16'h1978, 1'b0);
    endtask : t_land
    task automatic split_case(input logic [9:0] size, input logic [9:0] lines,
                              input int n, input logic [15:0] addr, input logic bot);
        cfg(1'b0, 8'h14, 8'h00, 16'h0100, 16'h0010, size, lines);
        pulse(1'b1);
        repeat (n) pulse(1'b0);
        at(addr, bot);
    endtask : split_case
    task automatic t_split();
        split_case(10'h003, 10'h0F0, 2, 16'h0250, 1'b0);
        split_case(10'h003, 10'h0F0, 3, 16'h0020, 1'b1);
        split_case(10'h003, 10'h0F0, 4, 16'h0048, 1'b1);
        split_case(10'h001, 10'h0F0, 1, 16'h0020, 1'b1);
        split_case(10'h002, 10'h002, 2, 16'h0250, 1'b0);
        split_case(10'h101, 10'h3FF, 256, 16'h2A00, 1'b0);
        split_case(10'h101, 10'h3FF, 257, 16'h0020, 1'b1);
        rd(ADDR_LINE_COUNT_LO, 8'h01);
        rd(ADDR_LINE_COUNT_HI, 8'h05);
        rd(ADDR_TOP_SIZE_HIGH, 8'h01);
        rd(ADDR_PANEL_LINES_HI, 8'h03);
    endtask : t_split
    task automatic t_rot();
        cfg(1'b1, 8'h14, 8'h28, 16'h0C81, 16'h0010, 10'h001, 10'h0F0);
        pulse(1'b1);
        at(16'h0C81, 1'b0);
        pulse(1'b0);
        at(16'h0CBD, 1'b0);
        rd(ADDR_FETCH_LO, 8'hBD);
        rd(ADDR_FETCH_HI, 8'h0C);
        rd(ADDR_MODE, 8'h01);
        rd(ADDR_SHOWN_WIDTH, 8'h14);
        rd(ADDR_LINE_OFFSET, 8'h28);
        rd(ADDR_BOT_START_LOW, 8'h10);
        rd(ADDR_BOT_START_HIGH, 8'h00);
        rd(ADDR_TOP_SIZE_LOW, 8'h01);
        rd(ADDR_PANEL_LINES_LO, 8'hF0);
    endtask : t_rot
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        t_land();
        t_split();
        t_rot();
        final_report();
    end
    // a hang counts as a mismatch
    initial begin
        #200000;
        miscompares++;
        final_report();
    end
endmodule : frame_fetch_addr_tb
